// *** rtl/tsc_map.vh ***
/*
  constants of the transceiver state controller: state and command codes,
  register selects and transition timing.
  assumes a 10 MHz system clock; times are whole microseconds.
*/
`ifndef TSC_MAP_VH
`define TSC_MAP_VH

// ----------------------------------------------------------------
// register selects on the register port
// ----------------------------------------------------------------
`define TSC_SEL_STATE 1'h0
`define TSC_SEL_CMD 1'h1
`define TSC_CMD_RESET_VAL 3'h0
`define TSC_CMD_MSB 2
`define TSC_CMD_LSB 0

// ----------------------------------------------------------------
// readable state codes
// ----------------------------------------------------------------
`define TSC_CODE_OFF 3'h2
`define TSC_CODE_PREP 3'h3
`define TSC_CODE_TX 3'h4
`define TSC_CODE_RX 3'h5
`define TSC_CODE_TRANS 3'h6
`define TSC_CODE_RESET 3'h7

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define TSC_CMD_NOP 3'h0
`define TSC_CMD_SLEEP 3'h1
`define TSC_CMD_OFF 3'h2
`define TSC_CMD_PREP 3'h3
`define TSC_CMD_TX 3'h4
`define TSC_CMD_RX 3'h5
`define TSC_CMD_RESET 3'h7

// ----------------------------------------------------------------
// transition times in us and derived cycle counts
// ----------------------------------------------------------------
// all sized to 16 bits so the cycle products fit the timer width
`define TSC_CLK_MHZ 16'h000A
`define TSC_T_OFF_PREP_US 16'h00C8
`define TSC_T_OFF_PREP_CYC (`TSC_T_OFF_PREP_US * `TSC_CLK_MHZ)
`define TSC_T_TXRX_PREP_US 16'h0002
`define TSC_T_TXRX_PREP_CYC (`TSC_T_TXRX_PREP_US * `TSC_CLK_MHZ)
`define TSC_T_PREP_TXRX_US 16'h0004
`define TSC_T_PREP_TXRX_CYC (`TSC_T_PREP_TXRX_US * `TSC_CLK_MHZ)
`define TSC_T_OFF_RX_US 16'h00C8
`define TSC_T_OFF_RX_CYC (`TSC_T_OFF_RX_US * `TSC_CLK_MHZ)
`define TSC_T_TO_OFF_US 16'h0001
`define TSC_T_TO_OFF_CYC (`TSC_T_TO_OFF_US * `TSC_CLK_MHZ)
`define TSC_T_SLEEP_OFF_US 16'h0001
`define TSC_T_SLEEP_OFF_CYC (`TSC_T_SLEEP_OFF_US * `TSC_CLK_MHZ)
`define TSC_T_RESET_US 16'h0001
`define TSC_T_RESET_CYC (`TSC_T_RESET_US * `TSC_CLK_MHZ)
`define TSC_T_WAKE_US 16'h02BC
`define TSC_T_WAKE_CYC (`TSC_T_WAKE_US * `TSC_CLK_MHZ)

`endif

// *** rtl/tsc_delay.v ***
/*
  tsc_delay: loadable down counter that times one state transition.
  assumes load_i is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
module tsc_delay #(
  parameter W = 16
) (
  input wire mclk_i,
  input wire resetn_i,
  input wire load_i,
  input wire [W-1:0] count_i,
  output wire busy_o,
  output reg done_o
);

  reg [W-1:0] cnt; // cycles left

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // a zero count still takes one cycle
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt <= {W{1'b0}};
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (load_i)
        cnt <= (count_i == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : count_i;
      else if (cnt != {W{1'b0}})
      begin
        cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        if (cnt == {{(W-1){1'b0}}, 1'b1})
          done_o <= 1'b1; // last cycle done
      end
    end
  end

  assign busy_o = (cnt != {W{1'b0}});

endmodule // tsc_delay

// *** rtl/tsc_cmd_queue.v ***
/*
  tsc_cmd_queue: command register of one transceiver with a one-entry
  pending command slot.
  assumes writes and takes are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
`include "tsc_map.vh"
module tsc_cmd_queue (
  input wire mclk_i,
  input wire resetn_i,
  input wire wr_i,
  input wire [2:0] cmd_i,
  input wire take_i,
  input wire clr_i,
  output reg valid_o,
  output reg [2:0] cmd_o,
  output reg [2:0] readback_o
);

  // ----------------------------------------------------------------
  // pending slot
  // ----------------------------------------------------------------
  // a write in the take cycle refills the slot, a newer write replaces
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      valid_o <= 1'b0;
      cmd_o <= `TSC_CMD_NOP;
      readback_o <= `TSC_CMD_RESET_VAL;
    end
    else if (wr_i)
    begin
      valid_o <= 1'b1; // each write queues a command
      cmd_o <= cmd_i;
      readback_o <= cmd_i;
    end
    else if (clr_i)
    begin
      valid_o <= 1'b0;
      readback_o <= `TSC_CMD_RESET_VAL;
    end
    else if (take_i)
      valid_o <= 1'b0;
  end

endmodule // tsc_cmd_queue

// *** rtl/tsc_top.v ***
/*
  tsc_top: state controller for the two transceivers of a dual-band radio,
  with the shared deep-sleep and wake-up sequencing.
  assumes the register port is driven by an spi slave on the same clock and
  that frame events and mode bits come from logic on the same clock.
  transceiver 0 is the sub-ghz one, transceiver 1 the 2.4 ghz one.
*/
`timescale 1ns/1ps
`include "tsc_map.vh"
module tsc_top #(
  parameter [15:0] WAKE_CYC = `TSC_T_WAKE_CYC,
  parameter [15:0] OFF_PREP_CYC = `TSC_T_OFF_PREP_CYC,
  parameter [15:0] TXRX_PREP_CYC = `TSC_T_TXRX_PREP_CYC,
  parameter [15:0] PREP_TXRX_CYC = `TSC_T_PREP_TXRX_CYC,
  parameter [15:0] OFF_RX_CYC = `TSC_T_OFF_RX_CYC,
  parameter [15:0] TO_OFF_CYC = `TSC_T_TO_OFF_CYC,
  parameter [15:0] SLEEP_OFF_CYC = `TSC_T_SLEEP_OFF_CYC,
  parameter [15:0] RESET_CYC = `TSC_T_RESET_CYC
) (
  input wire mclk_i,
  input wire resetn_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire reg_trx_i,
  input wire reg_sel_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire [1:0] iq_mode_i,
  input wire [1:0] tx_frame_done_i,
  input wire [1:0] receive_frame_end_flag_i,
  input wire clock_output_cfg_en_i,
  output wire [1:0] wake_interrupt_flag_o,
  output wire [1:0] ready_interrupt_flag_o,
  output wire [1:0] analog_reg_en_o,
  output wire [1:0] pll_lock_o,
  output wire [1:0] calib_start_o,
  output wire [1:0] tx_frontend_en_o,
  output wire [1:0] rx_frontend_en_o,
  output wire [1:0] tx_abort_o,
  output wire [1:0] rx_abort_o,
  output wire [1:0] trx_regs_reset_o,
  output wire [1:0] iq_receive_clock_pins_en_o,
  output wire [1:0] iq_transmit_clock_pins_en_o,
  output wire [1:0] iq_transmit_data_pins_en_o,
  output wire subghz_receive_data_pins_en_o,
  output wire band24_receive_data_pins_en_o,
  output reg crystal_oscillator_en_o,
  output reg digital_regulator_en_o,
  output reg clock_output_pin_en_o,
  output reg chip_regs_reset_o
);

  // ----------------------------------------------------------------
  // internal state encoding
  // ----------------------------------------------------------------
  localparam [2:0] S_OFF = 3'h0;
  localparam [2:0] S_PREP = 3'h1;
  localparam [2:0] S_TX = 3'h2;
  localparam [2:0] S_RX = 3'h3;
  localparam [2:0] S_SLEEP = 3'h4;
  localparam [2:0] S_TRANS = 3'h5;
  localparam [2:0] S_RESET = 3'h6;

  reg deep_r; // both transceivers in deep sleep
  reg waking; // wake delay running
  reg wake_load; // start the wake timer
  wire wake_done; // wake delay elapsed
  wire [1:0] is_sleep; // transceiver sits in sleep
  wire [1:0] wake_req; // off command taken in deep sleep
  wire [1:0] iq_rxd_en; // receive data pin enables per transceiver
  wire [2:0] cmd_rb0; // command readback, transceiver 0
  wire [2:0] cmd_rb1; // command readback, transceiver 1
  wire [2:0] code0; // state code, transceiver 0
  wire [2:0] code1; // state code, transceiver 1

  // ----------------------------------------------------------------
  // per transceiver controller
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_trx
      reg [2:0] st; // current state
      reg [2:0] tgt; // state reached when the timer ends
      reg by_cmd; // transition was commanded
      reg wake_end; // flag wake at the end
      reg tmr_load; // timer start pulse
      reg [15:0] tmr_cnt; // timer length
      reg [2:0] code; // readable state code
      reg wake_fl, rdy_fl, calib, abort_tx, abort_rx, clr;
      reg avreg, pll, txfe, rxfe, iq_rxclk, iq_txclk, iq_txd, iq_rxd;
      wire q_valid; // command pending
      wire [2:0] q_cmd; // pending command
      wire [2:0] q_rb; // command register readback
      wire tmr_busy; // transition timer running
      wire tmr_done; // transition timer elapsed
      wire idle; // ready to fetch a command
      wire take; // pending command consumed
      wire wr; // write to this command register
      wire go_pwr; // heading for a powered state

      assign wr = reg_wr_i & (reg_sel_i == `TSC_SEL_CMD) & (reg_trx_i == g);
      assign idle = (st != S_TRANS) & (st != S_RESET) & ~tmr_busy & ~tmr_load & ~waking;
      // in deep sleep every command is drained; only off has an effect
      assign take = q_valid & (deep_r | idle);
      assign wake_req[g] = take & deep_r & (q_cmd == `TSC_CMD_OFF);
      assign is_sleep[g] = (st == S_SLEEP);
      assign go_pwr = (tgt == S_PREP) | (tgt == S_TX) | (tgt == S_RX);

      tsc_cmd_queue u_queue (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .wr_i(wr),
        .cmd_i(reg_wdata_i[`TSC_CMD_MSB:`TSC_CMD_LSB]),
        .take_i(take),
        .clr_i(clr | chip_regs_reset_o),
        .valid_o(q_valid),
        .cmd_o(q_cmd),
        .readback_o(q_rb)
      );

      tsc_delay #(
        .W(16)
      ) u_delay (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .load_i(tmr_load),
        .count_i(tmr_cnt),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
      );

      // state machine: wake, timer end, command, frame end
      always @(posedge mclk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          st <= S_OFF;
          tgt <= S_OFF;
          by_cmd <= 1'b0;
          wake_end <= 1'b0;
          tmr_load <= 1'b0;
          tmr_cnt <= 16'h0000;
          wake_fl <= 1'b0;
          rdy_fl <= 1'b0;
          calib <= 1'b0;
          abort_tx <= 1'b0;
          abort_rx <= 1'b0;
          clr <= 1'b0;
        end
        else
        begin
          tmr_load <= 1'b0;
          wake_fl <= 1'b0;
          rdy_fl <= 1'b0;
          calib <= 1'b0;
          abort_tx <= 1'b0;
          abort_rx <= 1'b0;
          clr <= 1'b0;
          if (wake_done)
          begin
            st <= S_OFF;
            wake_fl <= 1'b1;
          end
          else if (tmr_done)
          begin
            st <= tgt;
            if ((tgt == S_PREP) & by_cmd)
              rdy_fl <= 1'b1;
            if (tgt == S_PREP)
              calib <= 1'b1;
            if (wake_end)
              wake_fl <= 1'b1;
          end
          else if (take & ~deep_r)
          begin
            by_cmd <= 1'b1;
            wake_end <= 1'b0;
            case (q_cmd)
              `TSC_CMD_SLEEP:
              begin
                if (st == S_OFF)
                begin
                  st <= S_SLEEP;
                  clr <= 1'b1;
                end
              end
              `TSC_CMD_OFF:
              begin
                if (st != S_OFF)
                begin
                  st <= S_TRANS;
                  tgt <= S_OFF;
                  tmr_load <= 1'b1;
                  tmr_cnt <= (st == S_SLEEP) ? SLEEP_OFF_CYC : TO_OFF_CYC;
                  wake_end <= (st == S_SLEEP);
                  abort_tx <= (st == S_TX);
                  abort_rx <= (st == S_RX);
                end
              end
              `TSC_CMD_PREP:
              begin
                if ((st == S_OFF) | (st == S_TX) | (st == S_RX))
                begin
                  st <= S_TRANS;
                  tgt <= S_PREP;
                  tmr_load <= 1'b1;
                  tmr_cnt <= (st == S_OFF) ? OFF_PREP_CYC : TXRX_PREP_CYC;
                  abort_tx <= (st == S_TX);
                  abort_rx <= (st == S_RX);
                end
              end
              `TSC_CMD_TX:
              begin
                if (st == S_PREP)
                begin
                  st <= S_TRANS;
                  tgt <= S_TX;
                  tmr_load <= 1'b1;
                  tmr_cnt <= PREP_TXRX_CYC;
                end
              end
              `TSC_CMD_RX:
              begin
                if ((st == S_PREP) | (st == S_OFF))
                begin
                  st <= S_TRANS;
                  tgt <= S_RX;
                  tmr_load <= 1'b1;
                  tmr_cnt <= (st == S_OFF) ? OFF_RX_CYC : PREP_TXRX_CYC;
                end
              end
              `TSC_CMD_RESET:
              begin
                st <= S_RESET;
                tgt <= S_OFF;
                tmr_load <= 1'b1;
                tmr_cnt <= RESET_CYC;
                wake_end <= 1'b1;
                clr <= 1'b1;
                abort_tx <= (st == S_TX);
                abort_rx <= (st == S_RX);
              end
              default:
              begin
                st <= st;
              end
            endcase
          end
          else if (idle & ~iq_mode_i[g] & (st == S_TX) & tx_frame_done_i[g])
          begin
            st <= S_TRANS;
            tgt <= S_PREP;
            by_cmd <= 1'b0;
            wake_end <= 1'b0;
            tmr_load <= 1'b1;
            tmr_cnt <= TXRX_PREP_CYC;
          end
          else if (idle & ~iq_mode_i[g] & (st == S_RX) & receive_frame_end_flag_i[g])
          begin
            st <= S_TRANS;
            tgt <= S_PREP;
            by_cmd <= 1'b0;
            wake_end <= 1'b0;
            tmr_load <= 1'b1;
            tmr_cnt <= TXRX_PREP_CYC;
          end
        end
      end

      // registered state code and analog/pin enables
      always @(posedge mclk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          code <= `TSC_CODE_OFF;
          avreg <= 1'b0;
          pll <= 1'b0;
          txfe <= 1'b0;
          rxfe <= 1'b0;
          iq_rxclk <= 1'b0;
          iq_txclk <= 1'b0;
          iq_txd <= 1'b0;
          iq_rxd <= 1'b0;
        end
        else
        begin
          case (st)
            S_OFF: code <= `TSC_CODE_OFF;
            S_PREP: code <= `TSC_CODE_PREP;
            S_TX: code <= `TSC_CODE_TX;
            S_RX: code <= `TSC_CODE_RX;
            S_TRANS: code <= `TSC_CODE_TRANS;
            default: code <= `TSC_CODE_RESET;
          endcase
          avreg <= (st == S_PREP) | (st == S_TX) | (st == S_RX) | ((st == S_TRANS) & go_pwr);
          pll <= (st == S_PREP) | (st == S_TX) | (st == S_RX);
          txfe <= (st == S_TX);
          rxfe <= (st == S_RX);
          iq_rxclk <= iq_mode_i[g] & ((st == S_PREP) | (st == S_TX) | (st == S_RX));
          iq_txclk <= iq_mode_i[g] & ((st == S_PREP) | (st == S_TX));
          iq_txd <= iq_mode_i[g] & ((st == S_PREP) | (st == S_TX));
          iq_rxd <= iq_mode_i[g] & (st == S_RX);
        end
      end

      assign wake_interrupt_flag_o[g] = wake_fl;
      assign ready_interrupt_flag_o[g] = rdy_fl;
      assign analog_reg_en_o[g] = avreg;
      assign pll_lock_o[g] = pll;
      assign calib_start_o[g] = calib;
      assign tx_frontend_en_o[g] = txfe;
      assign rx_frontend_en_o[g] = rxfe;
      assign tx_abort_o[g] = abort_tx;
      assign rx_abort_o[g] = abort_rx;
      assign trx_regs_reset_o[g] = clr;
      assign iq_receive_clock_pins_en_o[g] = iq_rxclk;
      assign iq_transmit_clock_pins_en_o[g] = iq_txclk;
      assign iq_transmit_data_pins_en_o[g] = iq_txd;
      assign iq_rxd_en[g] = iq_rxd;
    end
  endgenerate

  assign subghz_receive_data_pins_en_o = iq_rxd_en[0];
  assign band24_receive_data_pins_en_o = iq_rxd_en[1];
  assign cmd_rb0 = gen_trx[0].q_rb;
  assign cmd_rb1 = gen_trx[1].q_rb;
  assign code0 = gen_trx[0].code;
  assign code1 = gen_trx[1].code;

  // ----------------------------------------------------------------
  // deep sleep and wake-up sequencing
  // ----------------------------------------------------------------
  tsc_delay #(
    .W(16)
  ) u_wake_delay (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .load_i(wake_load),
    .count_i(WAKE_CYC),
    .busy_o(),
    .done_o(wake_done)
  );

  // enter deep sleep, wake on off command, restore clock output
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      deep_r <= 1'b0;
      waking <= 1'b0;
      wake_load <= 1'b0;
      crystal_oscillator_en_o <= 1'b1;
      digital_regulator_en_o <= 1'b1;
      clock_output_pin_en_o <= 1'b0;
      chip_regs_reset_o <= 1'b0;
    end
    else
    begin
      wake_load <= 1'b0;
      chip_regs_reset_o <= 1'b0;
      if (~deep_r & ~waking & (&is_sleep))
      begin
        deep_r <= 1'b1;
        crystal_oscillator_en_o <= 1'b0;
        digital_regulator_en_o <= 1'b0;
        clock_output_pin_en_o <= 1'b0;
      end
      else if (deep_r & (|wake_req))
      begin
        deep_r <= 1'b0;
        waking <= 1'b1;
        wake_load <= 1'b1;
        crystal_oscillator_en_o <= 1'b1;
        digital_regulator_en_o <= 1'b1;
      end
      else if (wake_done)
      begin
        waking <= 1'b0;
        chip_regs_reset_o <= 1'b1;
        clock_output_pin_en_o <= clock_output_cfg_en_i;
      end
      else if (~deep_r & ~waking)
        clock_output_pin_en_o <= clock_output_cfg_en_i;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // upper five bits of both registers read as zero
  always @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      if (reg_sel_i == `TSC_SEL_CMD)
        reg_rdata_o <= {5'h00, reg_trx_i ? cmd_rb1 : cmd_rb0};
      else
        reg_rdata_o <= {5'h00, reg_trx_i ? code1 : code0};
    end
  end

endmodule // tsc_top

// *** tb/tsc_sva.sv ***
/*
  tsc_sva: port-level timing checks of the transceiver state controller.
  assumes it is bound to tsc_top; one clock, async active-low reset.
*/
`timescale 1ns/1ps
module tsc_sva (
  input wire mclk_i,
  input wire resetn_i,
  input wire [1:0] iq_mode_i,
  input wire [1:0] wake_interrupt_flag_o,
  input wire [1:0] ready_interrupt_flag_o,
  input wire [1:0] analog_reg_en_o,
  input wire [1:0] pll_lock_o,
  input wire [1:0] calib_start_o,
  input wire [1:0] tx_frontend_en_o,
  input wire [1:0] rx_frontend_en_o,
  input wire [1:0] tx_abort_o,
  input wire [1:0] iq_transmit_data_pins_en_o,
  input wire subghz_receive_data_pins_en_o,
  input wire crystal_oscillator_en_o,
  input wire digital_regulator_en_o,
  input wire clock_output_pin_en_o,
  input wire chip_regs_reset_o
);
  // ----------------------------------------
  // checks on transceiver 0 and chip level
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  a_wake_both: assert property (chip_regs_reset_o |-> wake_interrupt_flag_o == 2'h3)
    else $error("wake flags not raised together");
  a_tx_fe_pll: assert property (tx_frontend_en_o[0] |-> pll_lock_o[0] && analog_reg_en_o[0])
    else $error("tx frontends without pll");
  a_rx_fe_pll: assert property (rx_frontend_en_o[0] |-> pll_lock_o[0])
    else $error("rx frontends without pll");
  a_prep_fe_off: assert property (calib_start_o[0] |-> !tx_frontend_en_o[0] && !rx_frontend_en_o[0])
    else $error("frontends on in prepare");
  a_ready_calib: assert property (ready_interrupt_flag_o[0] |-> calib_start_o[0])
    else $error("ready flag away from prepare entry");
  a_clock_output_pin_sleep: assert property (!crystal_oscillator_en_o |-> !clock_output_pin_en_o)
    else $error("clock output while oscillator off");
  a_osc_reg: assert property (crystal_oscillator_en_o == digital_regulator_en_o)
    else $error("oscillator and regulator differ");
  a_subghz_rx: assert property (subghz_receive_data_pins_en_o |-> $past(iq_mode_i[0]) && rx_frontend_en_o[0])
    else $error("subghz data pins outside iq receive");
  a_iq_tx_pll: assert property (iq_transmit_data_pins_en_o[0] |-> pll_lock_o[0])
    else $error("iq tx pins without pll");
  a_abort_tx: assert property (tx_abort_o[0] |-> ##[1:3] !tx_frontend_en_o[0])
    else $error("tx still on after abort");
  c_ready: cover property (ready_interrupt_flag_o[0]);
  c_wake: cover property (chip_regs_reset_o);
  c_subghz: cover property (subghz_receive_data_pins_en_o);
endmodule // tsc_sva

// *** tb/tsc_host.sv ***
/*
  tsc_host: host model driving the strobe register port.
  assumes tasks are entered at a falling clock edge.
*/
`timescale 1ns/1ps
module tsc_host (
  input wire mclk_i,
  input wire [7:0] reg_rdata_i,
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0,
  output logic reg_trx_o = 1'b0,
  output logic reg_sel_o = 1'b0,
  output logic [7:0] reg_wdata_o = 8'hA5
);
  // one write, then a quiet cycle; data shows the inverse when idle
  task automatic wr(input logic t, input logic s, input logic [7:0] d);
    reg_trx_o = t;
    reg_sel_o = s;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge mclk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
    @(negedge mclk_i);
  endtask
  // one read; data taken once it has settled
  task automatic rd(input logic t, input logic s, output logic [7:0] d);
    reg_trx_o = t;
    reg_sel_o = s;
    reg_rd_o = 1'b1;
    @(negedge mclk_i);
    reg_rd_o = 1'b0;
    @(negedge mclk_i);
    d = reg_rdata_i;
  endtask
endmodule // tsc_host

// *** tb/tsc_top_bench.sv ***
/*
  tsc_top_bench: self-checking bench of the state controller.
  assumes tsc_host for register traffic and tsc_sva bound to the top.
*/
`timescale 1ns/1ps
module tsc_top_bench;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [1:0] iq_mode_i = 2'h0;
  logic [1:0] tx_frame_done_i = 2'h0;
  logic [1:0] receive_frame_end_flag_i = 2'h0;
  logic clock_output_cfg_en_i = 1'b1;
  logic reg_wr_i, reg_rd_i, reg_trx_i, reg_sel_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, d;
  logic [1:0] wake_interrupt_flag_o, ready_interrupt_flag_o, tx_abort_o, rx_abort_o;
  logic [1:0] iq_transmit_data_pins_en_o;
  logic [1:0] iq_receive_clock_pins_en_o, iq_transmit_clock_pins_en_o;
  logic subghz_receive_data_pins_en_o, crystal_oscillator_en_o, clock_output_pin_en_o;
  logic chip_regs_reset_o;
  logic rdy, abt, crr; // sticky event seen
  logic clr_ev = 1'b0; // clears the sticky events
  logic [1:0] wak;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // rows: command, state reached, ready, wake, abort
  logic [8:0] rows [12] = '{{3'h4, 3'h2, 3'h0}, {3'h3, 3'h3, 3'h4}, {3'h4, 3'h4, 3'h0},
    {3'h3, 3'h3, 3'h5}, {3'h5, 3'h5, 3'h0}, {3'h2, 3'h2, 3'h1}, {3'h5, 3'h5, 3'h0},
    {3'h2, 3'h2, 3'h1}, {3'h7, 3'h2, 3'h2}, {3'h0, 3'h2, 3'h0}, {3'h1, 3'h7, 3'h0},
    {3'h2, 3'h2, 3'h2}};
  always #50 mclk_i = ~mclk_i;
  tsc_top #(.WAKE_CYC(16'h0028), .OFF_PREP_CYC(16'h001E), .OFF_RX_CYC(16'h001E)) dut_u (
    .mclk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_trx_i, .reg_sel_i, .reg_wdata_i,
    .reg_rdata_o, .iq_mode_i, .tx_frame_done_i, .receive_frame_end_flag_i,
    .clock_output_cfg_en_i, .wake_interrupt_flag_o, .ready_interrupt_flag_o,
    .analog_reg_en_o(), .pll_lock_o(), .calib_start_o(), .tx_frontend_en_o(),
    .rx_frontend_en_o(), .tx_abort_o, .rx_abort_o, .trx_regs_reset_o(),
    .iq_receive_clock_pins_en_o, .iq_transmit_clock_pins_en_o,
    .iq_transmit_data_pins_en_o, .subghz_receive_data_pins_en_o,
    .band24_receive_data_pins_en_o(), .crystal_oscillator_en_o,
    .digital_regulator_en_o(), .clock_output_pin_en_o, .chip_regs_reset_o);
  tsc_host host_u (.mclk_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_trx_o(reg_trx_i), .reg_sel_o(reg_sel_i),
    .reg_wdata_o(reg_wdata_i));
  // ----------------------------------------
  // event capture and hang guard
  // ----------------------------------------
  // sticky events, cleared in reset or on request
  always @(posedge mclk_i)
  begin
    if (!resetn_i || clr_ev)
      {rdy, abt, crr, wak} <= 5'h0;
    else
    begin
      rdy <= rdy | ready_interrupt_flag_o[0];
      wak <= wak | wake_interrupt_flag_o;
      abt <= abt | tx_abort_o[0] | rx_abort_o[0];
      crr <= crr | chip_regs_reset_o;
    end
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude;
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  // poll state until the transition code is gone
  task automatic settle(input logic t);
    repeat (4) @(negedge mclk_i);
    for (int k = 0; k < 100; k++)
    begin
      host_u.rd(t, 1'b0, d);
      // reset code shows before off, so wait past it as well
      if (d[2:0] !== 3'h6 && d[2:0] !== 3'h7) break;
    end
  endtask
  // one clock edge with the sticky events cleared
  task automatic clear_ev;
    clr_ev = 1'b1;
    @(negedge mclk_i);
    clr_ev = 1'b0;
  endtask
  task automatic cmd(input logic t, input logic [2:0] c);
    clear_ev();
    host_u.wr(t, 1'b1, {5'h0, c});
    settle(t);
  endtask
  task automatic st(input logic t, input logic [2:0] e);
    host_u.rd(t, 1'b0, d);
    chk("state", {5'h0, e}, {5'h0, d[2:0]});
  endtask
  task automatic pulse(input logic rx);
    clear_ev();
    if (rx) receive_frame_end_flag_i = 2'h1;
    else tx_frame_done_i = 2'h1;
    @(negedge mclk_i);
    {receive_frame_end_flag_i, tx_frame_done_i} = 4'h0;
    settle(1'b0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(negedge mclk_i);
    resetn_i = 1'b1;
    st(1'b0, 3'h2);
    host_u.rd(1'b0, 1'b1, d);
    chk("cmd reset", 8'h00, d);
    for (int i = 0; i < 12; i++)
    begin
      cmd(1'b0, rows[i][8:6]);
      st(1'b0, rows[i][5:3]);
      chk("ready", {7'h0, rows[i][2]}, {7'h0, rdy});
      chk("wake", {7'h0, rows[i][1]}, {7'h0, wak[0]});
      chk("abort", {7'h0, rows[i][0]}, {7'h0, abt});
    end
    host_u.wr(1'b0, 1'b1, 8'h03);
    host_u.wr(1'b0, 1'b1, 8'hFC);
    repeat (120) @(negedge mclk_i);
    st(1'b0, 3'h4);
    host_u.rd(1'b0, 1'b1, d);
    chk("cmd bits", 8'h04, d);
    cmd(1'b0, 3'h3);
    cmd(1'b0, 3'h4);
    pulse(1'b0);
    st(1'b0, 3'h3);
    chk("no ready", 8'h00, {7'h0, rdy});
    cmd(1'b0, 3'h5);
    pulse(1'b1);
    st(1'b0, 3'h3);
    cmd(1'b0, 3'h2);
    iq_mode_i = 2'h1;
    cmd(1'b0, 3'h3);
    chk("iq prep pins", 8'h07, {5'h0, iq_receive_clock_pins_en_o[0],
      iq_transmit_clock_pins_en_o[0], iq_transmit_data_pins_en_o[0]});
    cmd(1'b0, 3'h5);
    chk("iq rx pins", 8'h05, {5'h0, iq_receive_clock_pins_en_o[0],
      iq_transmit_clock_pins_en_o[0], subghz_receive_data_pins_en_o});
    cmd(1'b0, 3'h2);
    iq_mode_i = 2'h0;
    cmd(1'b0, 3'h1);
    cmd(1'b1, 3'h1);
    repeat (4) @(negedge mclk_i);
    chk("osc deep", 8'h00, {7'h0, crystal_oscillator_en_o});
    chk("clock_output_pin deep", 8'h00, {7'h0, clock_output_pin_en_o});
    clear_ev();
    host_u.wr(1'b1, 1'b1, 8'h02);
    repeat (60) @(negedge mclk_i);
    chk("wake both", 8'h03, {6'h0, wak});
    chk("regs reset", 8'h01, {7'h0, crr});
    chk("osc on", 8'h01, {7'h0, crystal_oscillator_en_o});
    chk("clock_output_pin on", 8'h01, {7'h0, clock_output_pin_en_o});
    st(1'b0, 3'h2);
    host_u.rd(1'b1, 1'b1, d);
    chk("cmd wake", 8'h00, d);
    conclude();
  end
endmodule // tsc_top_bench
bind tsc_top tsc_sva chk_u (.mclk_i, .resetn_i, .iq_mode_i, .wake_interrupt_flag_o,
  .ready_interrupt_flag_o, .analog_reg_en_o, .pll_lock_o, .calib_start_o,
  .tx_frontend_en_o, .rx_frontend_en_o, .tx_abort_o, .iq_transmit_data_pins_en_o,
  .subghz_receive_data_pins_en_o, .crystal_oscillator_en_o, .digital_regulator_en_o,
  .clock_output_pin_en_o, .chip_regs_reset_o);
